// File: design/spdec_regs.svh
// spdec_regs.svh: offsets, codes and timing counts for the step pulse decoder
// assumes: included by bare name; clock at 100 MHz
`ifndef SPDEC_REGS_SVH
`define SPDEC_REGS_SVH

`define SPDEC_CLK_MHZ 100
`define SPDEC_DIR_SETUP_NS 10000
`define SPDEC_DIR_SETUP_CYC ((`SPDEC_DIR_SETUP_NS * `SPDEC_CLK_MHZ + 999) / 1000)
`define SPDEC_RELEASE_GAP_NS 10000
`define SPDEC_RELEASE_GAP_CYC ((`SPDEC_RELEASE_GAP_NS * `SPDEC_CLK_MHZ + 999) / 1000)
`define SPDEC_PULSE_HI_CYC 16'h0005
`define SPDEC_PULSE_LO_CYC 16'h0005
`define SPDEC_ADDR_CTRL 4'h0
`define SPDEC_ADDR_STEP 4'h1
`define SPDEC_ADDR_STAT 4'h2
`define SPDEC_ADDR_CNT 4'h3
`define SPDEC_CTRL_MODE_BIT 0
`define SPDEC_CTRL_REL_BIT 1
`define SPDEC_STEP_DIR_BIT 0
`define SPDEC_STAT_BUSY_BIT 0

`endif

// File: design/spdec_pkg.sv
// spdec_pkg.sv: types shared by both ends of the step pulse link
// assumes: nothing
package spdec_pkg;
    typedef enum logic {SPDEC_MODE_ONE = 1'b0, SPDEC_MODE_TWO = 1'b1} spdec_mode_e;
    typedef enum logic {SPDEC_DIR_CCW = 1'b0, SPDEC_DIR_CW = 1'b1} spdec_dir_e;
endpackage

// File: design/spdec_if.sv
// spdec_if.sv: the isolated input lines between controller and driver
// assumes: a high level means the photocoupler conducts (on)
`timescale 1ns/1ns
`default_nettype none
interface spdec_if;
    logic step_pulse_in;
    logic dir_in;
    logic release_in;
    modport ctrl (output step_pulse_in, output dir_in, output release_in);
    modport drv (input step_pulse_in, input dir_in, input release_in);
endinterface
`default_nettype wire

// File: design/spdec_sync.sv
// spdec_sync.sv: two flip-flop synchroniser bank
// assumes: single clock, asynchronous active-low reset
`timescale 1ns/1ns
`default_nettype none
module spdec_sync #(
    parameter int W = 3
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_q <= '0;
            sync_q <= '0;
        end
        else
        begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end
    assign q_o = sync_q;
endmodule
`default_nettype wire

// File: design/spdec_drv.sv
// spdec_drv.sv: driver end, decodes isolated pulse inputs into step commands
// assumes: inputs high when on; mode strap is static or changed at rest
`timescale 1ns/1ns
`default_nettype none
module spdec_drv
    import spdec_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    spdec_if.drv link,
    input wire logic mode_two_i,
    output logic step_o,
    output logic step_cw_o,
    output logic winding_en_o
);
    // ******************************
    // input synchronisation
    // ******************************
    logic [2:0] sync_w;
    logic pulse_prev_q;
    logic dir_prev_q;
    spdec_sync #(.W(3)) spdec_sync_inst (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .d_i({link.release_in, link.dir_in, link.step_pulse_in}),
        .q_o(sync_w)
    );

    // ******************************
    // decoding
    // ******************************
    wire pulse_fall_w = pulse_prev_q & ~sync_w[0];
    wire dir_fall_w = dir_prev_q & ~sync_w[1];
    wire one_mode_w = (mode_two_i == SPDEC_MODE_ONE);
    wire req_w = one_mode_w ? pulse_fall_w : (pulse_fall_w | dir_fall_w);
    wire cw_w = one_mode_w ? sync_w[1] : pulse_fall_w;

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            pulse_prev_q <= 1'b0;
            dir_prev_q <= 1'b0;
            step_o <= 1'b0;
            step_cw_o <= 1'b0;
            winding_en_o <= 1'b1;
        end
        else
        begin
            pulse_prev_q <= sync_w[0];
            dir_prev_q <= sync_w[1];
            step_o <= req_w;
            step_cw_o <= cw_w;
            winding_en_o <= ~sync_w[2];
        end
    end
endmodule
`default_nettype wire

// File: design/spdec_ctrl.sv
// spdec_ctrl.sv: controller end, register port commands into isolated pulses
// assumes: software port with read data one cycle after read strobe
// assumes: the far end decodes the link lines as the mode bit sets them
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "spdec_regs.svh"
module spdec_ctrl
    import spdec_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    spdec_if.ctrl link,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o
);
    typedef enum logic [1:0] {
        SPDEC_ST_IDLE = 2'b00,
        SPDEC_ST_SETUP = 2'b01,
        SPDEC_ST_HIGH = 2'b10,
        SPDEC_ST_LOW = 2'b11
    } spdec_st_e;

    localparam logic [15:0] SETUP_CYC = 16'(`SPDEC_DIR_SETUP_CYC);
    localparam logic [15:0] GAP_CYC = 16'(`SPDEC_RELEASE_GAP_CYC);

    // ******************************
    // helpers
    // ******************************
    function automatic logic [15:0] spdec_dec_sat(input logic [15:0] v);
        spdec_dec_sat = (v == 16'h0000) ? 16'h0000 : v - 16'h0001;
    endfunction

    // ******************************
    // registers
    // ******************************
    spdec_st_e st_q, st_d;
    logic mode_q;
    logic rel_q;
    logic dir_q, dir_d;
    logic fwd_q, fwd_d;
    logic rev_q, rev_d;
    logic dir_line_q;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] gap_q;
    logic [15:0] steps_q;

    wire wr_ctrl_w = wr_i & (addr_i == `SPDEC_ADDR_CTRL);
    wire wr_step_w = wr_i & (addr_i == `SPDEC_ADDR_STEP);
    wire busy_w = (st_q != SPDEC_ST_IDLE);
    wire cw_req_w = wdata_i[`SPDEC_STEP_DIR_BIT];
    wire start_w = wr_step_w & ~busy_w & ~rel_q & (gap_q == 16'h0000);
    wire dir_chg_w = (cw_req_w != dir_q);
    wire dir_line_d = (mode_q == SPDEC_MODE_ONE) ? dir_d : rev_d;

    // ******************************
    // pulse sequencer
    // ******************************
    always_comb
    begin
        st_d = st_q;
        dir_d = dir_q;
        fwd_d = 1'b0;
        rev_d = 1'b0;
        cnt_d = spdec_dec_sat(cnt_q);
        unique case (st_q)
            SPDEC_ST_IDLE:
            begin
                if (start_w)
                begin
                    if (dir_chg_w)
                    begin
                        dir_d = cw_req_w;
                        cnt_d = SETUP_CYC;
                        st_d = SPDEC_ST_SETUP;
                    end
                    else
                    begin
                        dir_d = cw_req_w;
                        cnt_d = `SPDEC_PULSE_HI_CYC;
                        st_d = SPDEC_ST_HIGH;
                    end
                end
            end
            SPDEC_ST_SETUP:
            begin
                if (cnt_q == 16'h0000)
                begin
                    cnt_d = `SPDEC_PULSE_HI_CYC;
                    st_d = SPDEC_ST_HIGH;
                end
            end
            SPDEC_ST_HIGH:
            begin
                fwd_d = (mode_q == SPDEC_MODE_ONE) | dir_q;
                rev_d = (mode_q == SPDEC_MODE_TWO) & ~dir_q;
                if (cnt_q == 16'h0000)
                begin
                    fwd_d = 1'b0;
                    rev_d = 1'b0;
                    cnt_d = `SPDEC_PULSE_LO_CYC; // fall issues the step
                    st_d = SPDEC_ST_LOW;
                end
            end
            SPDEC_ST_LOW:
            begin
                if (cnt_q == 16'h0000)
                begin
                    st_d = SPDEC_ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            st_q <= SPDEC_ST_IDLE;
            cnt_q <= 16'h0000;
            dir_q <= 1'b0;
            fwd_q <= 1'b0;
            rev_q <= 1'b0;
            dir_line_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            dir_q <= dir_d;
            fwd_q <= fwd_d;
            rev_q <= rev_d;
            dir_line_q <= dir_line_d;
        end
    end

    // ******************************
    // control, release gap, counter
    // ******************************
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            mode_q <= 1'b0;
            rel_q <= 1'b0;
            gap_q <= 16'h0000;
            steps_q <= 16'h0000;
        end
        else
        begin
            if (wr_ctrl_w)
            begin
                mode_q <= wdata_i[`SPDEC_CTRL_MODE_BIT];
                rel_q <= wdata_i[`SPDEC_CTRL_REL_BIT];
            end
            if (rel_q)
                gap_q <= GAP_CYC;
            else
                gap_q <= spdec_dec_sat(gap_q);
            if (st_q == SPDEC_ST_HIGH && st_d == SPDEC_ST_LOW)
                steps_q <= steps_q + 16'h0001;
        end
    end

    // ******************************
    // read port
    // ******************************
    wire [15:0] ctrl_rd_w = {14'h0000, rel_q, mode_q};
    wire [15:0] stat_rd_w = {15'h0000, busy_w | (gap_q != 16'h0000)};
    wire [15:0] rd_sel_w = (addr_i == `SPDEC_ADDR_CTRL) ? ctrl_rd_w :
                           (addr_i == `SPDEC_ADDR_STEP) ? {15'h0000, dir_q} :
                           (addr_i == `SPDEC_ADDR_STAT) ? stat_rd_w :
                           (addr_i == `SPDEC_ADDR_CNT) ? steps_q : 16'h0000;

    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            rdata_o <= 16'h0000;
        else
            rdata_o <= rd_i ? rd_sel_w : 16'h0000;
    end

    // ******************************
    // link outputs
    // ******************************
    assign link.step_pulse_in = fwd_q;
    assign link.dir_in = dir_line_q;
    assign link.release_in = rel_q;
endmodule
`default_nettype wire

// File: dv/spdec_properties.sv
// spdec_properties.sv: checks on the isolated link and the driver outputs
// assumes: instantiated beside the link interface in the bench
`timescale 1ns/1ns
`default_nettype none
module spdec_properties (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic step_pulse_in,
    input wire logic dir_in,
    input wire logic release_in,
    input wire logic mode_two_i,
    input wire logic step_o,
    input wire logic step_cw_o,
    input wire logic winding_en_o
);
    // ****************
    // age counters
    // ****************
    logic [10:0] dir_age_q;
    logic [10:0] rel_age_q;
    logic [10:0] fwd_age_q;
    logic dir_old_q;
    logic rel_old_q;
    logic fwd_old_q;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    always_ff @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            dir_age_q <= 11'h7ff;
            rel_age_q <= 11'h7ff;
            fwd_age_q <= 11'h7ff;
            dir_old_q <= 1'b0;
            rel_old_q <= 1'b0;
            fwd_old_q <= 1'b0;
        end
        else
        begin
            dir_age_q <= (dir_in != dir_old_q) ? 11'h000 : dir_age_q + {10'h000, ~&dir_age_q};
            rel_age_q <= (rel_old_q && !release_in) ? 11'h000 : rel_age_q + {10'h000, ~&rel_age_q};
            fwd_age_q <= (step_pulse_in != fwd_old_q) ? 11'h000 : fwd_age_q + {10'h000, ~&fwd_age_q};
            dir_old_q <= dir_in;
            rel_old_q <= release_in;
            fwd_old_q <= step_pulse_in;
        end
    end
    // ****************
    // properties
    // ****************
    AST_ONE_CW: assert property (!mode_two_i && dir_in && $fell(step_pulse_in) |-> ##3 step_o && step_cw_o)
        else $error("one-pulse cw step missing");
    AST_ONE_CCW: assert property (!mode_two_i && !dir_in && $fell(step_pulse_in) |-> ##3 step_o && !step_cw_o)
        else $error("one-pulse ccw step missing");
    AST_TWO_CW: assert property (mode_two_i && $fell(step_pulse_in) |-> ##3 step_o && step_cw_o)
        else $error("two-pulse cw step missing");
    AST_TWO_CCW: assert property (mode_two_i && $fell(dir_in) |-> ##3 step_o && !step_cw_o)
        else $error("two-pulse ccw step missing");
    AST_STEP_ONE: assert property (step_o |=> !step_o)
        else $error("step request longer than one cycle");
    AST_REL_ON: assert property (release_in [*3] |=> !winding_en_o)
        else $error("winding current not cut");
    AST_REL_OFF: assert property (!release_in [*3] |=> winding_en_o)
        else $error("winding current not restored");
    AST_NO_BOTH: assert property (mode_two_i |-> !(step_pulse_in && dir_in))
        else $error("both pulse lines on");
    AST_DIR_SETUP: assert property ($rose(step_pulse_in) |-> dir_age_q >= 11'h3e7)
        else $error("direction setup too short");
    AST_REV_SETUP: assert property (mode_two_i && $rose(dir_in) |-> fwd_age_q >= 11'h3e7)
        else $error("reverse pulse too soon after forward pulse");
    AST_REL_GAP: assert property ($rose(step_pulse_in) || (mode_two_i && $rose(dir_in)) |-> rel_age_q >= 11'h3e7)
        else $error("pulse too soon after release");
    cover property (step_o && step_cw_o);
    cover property (step_o && !step_cw_o);
    cover property (mode_two_i && step_o && !step_cw_o);
    cover property (!winding_en_o);
endmodule
`default_nettype wire

// File: dv/step_pulse_input_decoder_bench.sv
// step_pulse_input_decoder_bench.sv: both ends joined, driven by register port
// assumes: 100 MHz clock, register map of spdec_regs.svh
`timescale 1ns/1ns
`default_nettype none
`include "spdec_regs.svh"
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %h got %h", n, e, s); end end
module step_pulse_input_decoder_bench;
    // ****************
    // harness
    // ****************
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic mode_two = 1'b0;
    logic [15:0] rdata;
    logic step;
    logic step_cw;
    logic winding_en;
    logic [7:0] steps = 8'h00;
    logic [7:0] cws = 8'h00;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    spdec_if link_if ();
    spdec_ctrl spdec_ctrl_inst (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .link(link_if.ctrl),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata));
    spdec_drv spdec_drv_inst (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .link(link_if.drv),
        .mode_two_i(mode_two), .step_o(step), .step_cw_o(step_cw), .winding_en_o(winding_en));
    spdec_properties spdec_properties_inst (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
        .step_pulse_in(link_if.step_pulse_in), .dir_in(link_if.dir_in), .release_in(link_if.release_in),
        .mode_two_i(mode_two), .step_o(step), .step_cw_o(step_cw), .winding_en_o(winding_en));
    always #5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i)
    begin
        cyc++;
        if (step === 1'b1) steps <= steps + 8'h01;
        if (step === 1'b1 && step_cw === 1'b1) cws <= cws + 8'h01;
        if (cyc == 20000)
        begin
            error_cnt++;
            give_verdict();
        end
    end
    task give_verdict();
        if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk_i);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge ref_clk_i);
        wr_s <= 1'b0;
    endtask
    task rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk_i);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    task idle();
        logic [15:0] v;
        for (int i = 0; i < 2000; i++)
        begin
            rd(`SPDEC_ADDR_STAT, v);
            if (v[0] === 1'b0) break;
        end
        `CHK("busy", 1'b0, v[0])
    endtask
    // ****************
    // scenarios
    // ****************
    task s_one_pulse();
        logic [15:0] v;
        wr(`SPDEC_ADDR_STEP, 16'h0001);
        wr(`SPDEC_ADDR_STEP, 16'h0000);
        idle();
        `CHK("steps", 8'h01, steps)
        `CHK("cw", 8'h01, cws)
        rd(`SPDEC_ADDR_STEP, v);
        `CHK("last_dir", 16'h0001, v)
        wr(`SPDEC_ADDR_STEP, 16'h0000);
        idle();
        `CHK("steps", 8'h02, steps)
        `CHK("cw", 8'h01, cws)
        rd(4'h9, v);
        `CHK("unmapped", 16'h0000, v)
    endtask
    task s_two_pulse();
        wr(`SPDEC_ADDR_CTRL, 16'h0001);
        mode_two <= 1'b1;
        wr(`SPDEC_ADDR_STEP, 16'h0001);
        idle();
        `CHK("steps", 8'h03, steps)
        `CHK("cw", 8'h02, cws)
        wr(`SPDEC_ADDR_STEP, 16'h0000);
        idle();
        `CHK("steps", 8'h04, steps)
        `CHK("cw", 8'h02, cws)
    endtask
    task s_release();
        logic [15:0] v;
        wr(`SPDEC_ADDR_CTRL, 16'h0003);
        repeat (5) @(posedge ref_clk_i);
        `CHK("winding", 1'b0, winding_en)
        rd(`SPDEC_ADDR_CTRL, v);
        `CHK("ctrl", 16'h0003, v)
        wr(`SPDEC_ADDR_STEP, 16'h0001);
        rd(`SPDEC_ADDR_STAT, v);
        `CHK("busy", 1'b1, v[0])
        wr(`SPDEC_ADDR_CTRL, 16'h0001);
        repeat (5) @(posedge ref_clk_i);
        `CHK("winding", 1'b1, winding_en)
        wr(`SPDEC_ADDR_STEP, 16'h0001);
        rd(`SPDEC_ADDR_STAT, v);
        `CHK("busy", 1'b1, v[0])
        idle();
        `CHK("steps", 8'h04, steps)
        wr(`SPDEC_ADDR_STEP, 16'h0001);
        idle();
        `CHK("cw", 8'h03, cws)
        rd(`SPDEC_ADDR_CNT, v);
        `CHK("count", 16'h0005, v)
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        `CHK("winding", 1'b1, winding_en)
        s_one_pulse();
        s_two_pulse();
        s_release();
        give_verdict();
    end
endmodule
`default_nettype wire
